// File: design/edspi_map.svh
`ifndef EDSPI_MAP_SVH
`define EDSPI_MAP_SVH
// Channel count and frame sizes
`define EDSPI_CHANNELS       4
`define EDSPI_WORD_BITS      16
`define EDSPI_BYTE_BITS      8
`define EDSPI_COUNT_WIDTH    8
// Command word field positions (low nibble injectors, next gates)
`define EDSPI_INJ_LSB        0
`define EDSPI_GATE_LSB       4
`define EDSPI_MODE_LSB       8
`define EDSPI_TEN_BIT        12
// Reset values
`define EDSPI_CMD_RESET      16'h0000
`define EDSPI_NIB_RESET      4'h0
// Supply filter timing
`define EDSPI_CLK_MHZ        125
`define EDSPI_POR_FILT_NS    1000
`define EDSPI_POR_FILT_CYC   ((`EDSPI_POR_FILT_NS * `EDSPI_CLK_MHZ + 999) / 1000)
`endif

// File: design/edspi_pkg.sv
package edspi_pkg;
    typedef struct packed {
        logic [3:0] injector;
        logic [3:0] gate;
    } edspi_drive_type;
    typedef struct packed {
        logic       sclk;
        logic       cs_n;
        logic       mosi;
    } edspi_link_type;
    typedef enum logic [1:0] {
        EDSPI_SLEEP,
        EDSPI_POR,
        EDSPI_NORMAL
    } edspi_power_type;
endpackage : edspi_pkg

// File: design/edspi_output_control.sv
`include "edspi_map.svh"
`timescale 1ns/1ps
`default_nettype none
module edspi_output_control
    import edspi_pkg::*;
#(
    parameter int CHANNELS = `EDSPI_CHANNELS,
    parameter int POR_FILTER_CYCLES = `EDSPI_POR_FILT_CYC
)
(
    // Clock and reset
    input  wire logic                clock_in,
    input  wire logic                rst_in,
    // Serial link from host
    input  wire logic                sclk_in,
    input  wire logic                cs_n_in,
    input  wire logic                mosi_in,
    output logic                     miso_out,
    output logic                     miso_oe_out,
    // Supplies
    input  wire logic                logic_supply_ok_in,
    input  wire logic                battery_supply_ok_in,
    // Parallel control
    input  wire logic                global_output_gate_n_in,
    input  wire logic [CHANNELS-1:0] injector_parallel_in,
    input  wire logic [CHANNELS-1:0] gate_parallel_in,
    // Analog comparator results
    input  wire logic [CHANNELS-1:0] drain_feedback_in,
    input  wire logic                coil_above_nominal_in,
    input  wire logic                coil_above_max_in,
    input  wire logic [CHANNELS-1:0] driver_fault_in,
    // Current-flag pins, inputs in ten-cylinder mode, outputs otherwise
    input  wire logic                overcurrent_flag_in,
    input  wire logic                nominal_current_flag_in,
    output logic                     overcurrent_flag_out,
    output logic                     overcurrent_flag_oe_out,
    output logic                     nominal_current_flag_out,
    output logic                     nominal_current_flag_oe_out,
    // Drives and indicators
    output logic [CHANNELS-1:0]      injector_drive_out,
    output logic [CHANNELS-1:0]      gate_drive_out,
    output logic                     spark_active_n_out,
    output logic                     spark_active_n_oe_out,
    output logic [CHANNELS-1:0]      general_gate_mode_out,
    output logic                     ten_cylinder_mode_out,
    output logic [CHANNELS-1:0]      feedback_diag_enable_out,
    output logic                     awake_out
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int SYNC_BITS = 12;
    logic [SYNC_BITS-1:0] sync1_reg;
    logic [SYNC_BITS-1:0] sync2_reg;
    logic [SYNC_BITS-1:0] raw_in;
    assign raw_in = {drain_feedback_in, coil_above_nominal_in,
                     coil_above_max_in, overcurrent_flag_in,
                     nominal_current_flag_in, logic_supply_ok_in,
                     sclk_in, cs_n_in, mosi_in};
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            sync1_reg <= 12'h0C2;
            sync2_reg <= 12'h0C2;
        end
        else
        begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end
    logic [CHANNELS-1:0] fb_s;
    logic                nom_s;
    logic                max_s;
    logic                ocf_pin_s;
    logic                ncf_pin_s;
    logic                vdd_s;
    edspi_link_type      link_s;
    assign {fb_s, nom_s, max_s, ocf_pin_s, ncf_pin_s, vdd_s} =
        sync2_reg[SYNC_BITS-1:3];
    assign link_s = sync2_reg[2:0];

    // ****************************************
    // Supply state and filtered power-on reset
    // ****************************************
    edspi_power_type     power_reg;
    logic [15:0]         por_cnt_reg;
    logic                clear_state;
    always_ff @(posedge clock_in)
    begin
        if (rst_in || !vdd_s || !battery_supply_ok_in)
        begin
            power_reg   <= EDSPI_SLEEP;
            por_cnt_reg <= 16'h0000;
        end
        else
        begin
            unique case (power_reg)
                EDSPI_SLEEP:
                begin
                    power_reg   <= EDSPI_POR;
                    por_cnt_reg <= 16'h0000;
                end
                EDSPI_POR:
                begin
                    if (por_cnt_reg >= 16'(POR_FILTER_CYCLES - 1))
                        power_reg <= EDSPI_NORMAL;
                    else
                        por_cnt_reg <= por_cnt_reg + 16'h0001;
                end
                EDSPI_NORMAL:
                    power_reg <= EDSPI_NORMAL;
            endcase
        end
    end
    assign clear_state = rst_in || (power_reg != EDSPI_NORMAL);
    assign awake_out   = (power_reg == EDSPI_NORMAL);

    // ****************************************
    // Link edge detection
    // ****************************************
    edspi_link_type link_d_reg;
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            link_d_reg <= 3'b010;
        else
            link_d_reg <= link_s;
    end
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic selected;
    assign selected  = !link_s.cs_n && awake_out;
    assign sclk_rise = selected && link_s.sclk && !link_d_reg.sclk;
    assign sclk_fall = selected && !link_s.sclk && link_d_reg.sclk;
    assign cs_fall   = !link_s.cs_n && link_d_reg.cs_n;
    assign cs_rise   = link_s.cs_n && !link_d_reg.cs_n;

    // ****************************************
    // Receive shift register and bit count
    // ****************************************
    logic [`EDSPI_WORD_BITS-1:0]   rx_reg;
    logic [`EDSPI_COUNT_WIDTH-1:0] bits_reg;
    always_ff @(posedge clock_in)
    begin
        if (clear_state || cs_fall)
        begin
            rx_reg   <= `EDSPI_CMD_RESET;
            bits_reg <= 8'h00;
        end
        else if (sclk_rise)
        begin
            rx_reg <= {rx_reg[`EDSPI_WORD_BITS-2:0], link_s.mosi};
            if (bits_reg != 8'hFF)
                bits_reg <= bits_reg + 8'h01;
        end
    end

    // ****************************************
    // Transmit shift register
    // ****************************************
    logic [`EDSPI_WORD_BITS-1:0] tx_reg;
    logic                        miso_reg;
    logic                        oe_reg;
    logic [`EDSPI_WORD_BITS-1:0] status_word;
    // Fault per driver: one means faulted; upper byte repeats the same fault bits
    assign status_word = {4'h0, driver_fault_in, 4'h0, driver_fault_in};
    always_ff @(posedge clock_in)
    begin
        if (clear_state)
        begin
            tx_reg   <= `EDSPI_CMD_RESET;
            miso_reg <= 1'b0;
            oe_reg   <= 1'b0;
        end
        else if (cs_fall)
        begin
            tx_reg   <= {status_word[`EDSPI_WORD_BITS-2:0], 1'b0};
            miso_reg <= status_word[`EDSPI_WORD_BITS-1];
            oe_reg   <= 1'b1;
        end
        else if (cs_rise || link_s.cs_n)
            oe_reg <= 1'b0;
        else if (sclk_fall)
        begin
            // Bit stays until next fall, so host samples on rise
            miso_reg <= tx_reg[`EDSPI_WORD_BITS-1];
            tx_reg   <= {tx_reg[`EDSPI_WORD_BITS-2:0], 1'b0};
        end
    end
    assign miso_out    = miso_reg;
    assign miso_oe_out = oe_reg;

    // ****************************************
    // Command commit
    // ****************************************
    // Longer frames of whole bytes (up to 248 bits) keep the last sixteen bits shifted in
    logic [`EDSPI_WORD_BITS-1:0] cmd_reg;
    logic                        frame_ok;
    assign frame_ok = (bits_reg >= 8'(`EDSPI_WORD_BITS)) &&
                      (bits_reg[2:0] == 3'b000);
    always_ff @(posedge clock_in)
    begin
        if (clear_state)
            cmd_reg <= `EDSPI_CMD_RESET;
        else if (cs_rise && frame_ok)
            cmd_reg <= rx_reg;
    end
    logic [CHANNELS-1:0] spi_inj;
    logic [CHANNELS-1:0] spi_gate;
    logic [CHANNELS-1:0] gp_mode;
    logic                ten_mode;
    assign spi_inj  = cmd_reg[`EDSPI_INJ_LSB +: CHANNELS];
    assign spi_gate = cmd_reg[`EDSPI_GATE_LSB +: CHANNELS];
    assign gp_mode  = cmd_reg[`EDSPI_MODE_LSB +: CHANNELS];
    assign ten_mode = cmd_reg[`EDSPI_TEN_BIT];
    assign general_gate_mode_out    = gp_mode;
    assign ten_cylinder_mode_out    = ten_mode;
    assign feedback_diag_enable_out = gp_mode;

    // ****************************************
    // Overcurrent latch-off
    // ****************************************
    logic [CHANNELS-1:0] latch_req;
    logic [CHANNELS-1:0] latched_reg;
    logic [CHANNELS-1:0] gate_req;
    logic [CHANNELS-1:0] on_req_gate;
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1)
        begin : g_ch
            // Ten-cylinder: even channels from one pin, odd from other
            assign latch_req[ch] = ten_mode ?
                ((ch % 2 == 0) ? ocf_pin_s : ncf_pin_s) : max_s;
            assign on_req_gate[ch] = gp_mode[ch] ?
                (gate_parallel_in[ch] | spi_gate[ch]) :
                gate_parallel_in[ch];
            // Latch holds until the input request drops
            always_ff @(posedge clock_in)
            begin
                if (clear_state || !gate_parallel_in[ch])
                    latched_reg[ch] <= 1'b0;
                else if (latch_req[ch] && !gp_mode[ch])
                    latched_reg[ch] <= 1'b1;
            end
            assign gate_req[ch] = on_req_gate[ch] && !latched_reg[ch] &&
                !(latch_req[ch] && !gp_mode[ch]);
        end
    endgenerate

    // ****************************************
    // Output drives
    // ****************************************
    edspi_drive_type drive_reg;
    edspi_drive_type drive_next;
    logic            spark_n_reg;
    always_comb
    begin
        drive_next.injector = injector_parallel_in | spi_inj;
        drive_next.gate     = gate_req;
        if (global_output_gate_n_in)
            drive_next = '0;
    end
    always_ff @(posedge clock_in)
    begin
        if (clear_state)
        begin
            drive_reg   <= '0;
            spark_n_reg <= 1'b1;
        end
        else
        begin
            drive_reg   <= drive_next;
            spark_n_reg <= !(|fb_s);
        end
    end
    assign injector_drive_out    = drive_reg.injector;
    assign gate_drive_out        = drive_reg.gate;
    // Open-drain: only ever pulls low
    assign spark_active_n_out    = 1'b0;
    assign spark_active_n_oe_out = !spark_n_reg;

    // ****************************************
    // Current flag pins
    // ****************************************
    logic nom_flag_reg;
    logic max_flag_reg;
    always_ff @(posedge clock_in)
    begin
        if (clear_state)
        begin
            nom_flag_reg <= 1'b0;
            max_flag_reg <= 1'b0;
        end
        else
        begin
            nom_flag_reg <= nom_s;
            max_flag_reg <= max_s;
        end
    end
    assign nominal_current_flag_out    = nom_flag_reg;
    assign overcurrent_flag_out        = max_flag_reg;
    assign nominal_current_flag_oe_out = !ten_mode;
    assign overcurrent_flag_oe_out     = !ten_mode;

endmodule : edspi_output_control
`default_nettype wire

// File: verification/edspi_output_control_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ******************************
// Port checks of output control
// ******************************
module edspi_output_control_asserts
    import edspi_pkg::*;
#(
    parameter int CHANNELS = 4
)
(
    // Clock, reset, link
    input wire logic                clock_in,
    input wire logic                rst_in,
    input wire logic                sclk_in,
    input wire logic                cs_n_in,
    input wire logic                miso_out,
    input wire logic                miso_oe_out,
    // Control and flags
    input wire logic                global_output_gate_n_in,
    input wire logic [CHANNELS-1:0] drain_feedback_in,
    input wire logic                coil_above_nominal_in,
    input wire logic                nominal_current_flag_out,
    input wire logic                nominal_current_flag_oe_out,
    input wire logic                overcurrent_flag_oe_out,
    input wire logic [CHANNELS-1:0] injector_drive_out,
    input wire logic [CHANNELS-1:0] gate_drive_out,
    input wire logic                spark_active_n_out,
    input wire logic                spark_active_n_oe_out,
    input wire logic [CHANNELS-1:0] general_gate_mode_out,
    input wire logic                ten_cylinder_mode_out,
    input wire logic                awake_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    property p_gate_off;
        global_output_gate_n_in |=> {injector_drive_out, gate_drive_out} == '0;
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("drive on while gate high");
    property p_miso_hiz;
        cs_n_in [*5] |-> !miso_oe_out;
    endproperty
    a_miso_hiz: assert property (p_miso_hiz)
        else $error("serial output driven while deselected");
    property p_oe_on;
        $fell(cs_n_in) && awake_out |-> ##[2:4] miso_oe_out;
    endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("serial output not enabled on select");
    property p_miso_hold;
        $rose(sclk_in) && !cs_n_in |=> $stable(miso_out) [*4];
    endproperty
    a_miso_hold: assert property (p_miso_hold)
        else $error("serial output moved while clock high");
    property p_spark;
        $stable(drain_feedback_in) [*4] |->
            spark_active_n_oe_out == (drain_feedback_in != '0)
            && !spark_active_n_out;
    endproperty
    a_spark: assert property (p_spark)
        else $error("spark output wrong");
    property p_sleep_off;
        !awake_out && !$past(awake_out) |->
            {injector_drive_out, gate_drive_out} == '0;
    endproperty
    a_sleep_off: assert property (p_sleep_off)
        else $error("drive on while not awake");
    property p_nominal;
        $stable(coil_above_nominal_in) [*4] ##0
            (awake_out && !ten_cylinder_mode_out) |->
            nominal_current_flag_out == coil_above_nominal_in;
    endproperty
    a_nominal: assert property (p_nominal)
        else $error("nominal flag wrong");
    property p_flag_dir;
        $stable(ten_cylinder_mode_out) [*2] |->
            nominal_current_flag_oe_out == !ten_cylinder_mode_out
            && overcurrent_flag_oe_out == !ten_cylinder_mode_out;
    endproperty
    a_flag_dir: assert property (p_flag_dir)
        else $error("flag pin direction wrong");
    property p_commit;
        $changed({general_gate_mode_out, ten_cylinder_mode_out}) |-> cs_n_in;
    endproperty
    a_commit: assert property (p_commit)
        else $error("command changed while selected");
endmodule : edspi_output_control_asserts
bind edspi_output_control edspi_output_control_asserts
    #(.CHANNELS(CHANNELS)) i_edspi_output_control_asserts (.*);
`default_nettype wire

// File: verification/edspi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ***************************
// Host acting as link master
// ***************************
module edspi_host_model
    import edspi_pkg::*;
(
    // Clock and link
    input  wire logic     clock_in,
    output var edspi_link_type link_out,
    input  wire logic     miso_in,
    input  wire logic     miso_oe_in
);
    logic last_reg;
    logic line;
    // Released line shows inverse, never a stale copy
    assign line = miso_oe_in ? miso_in : ~last_reg;
    always_ff @(posedge clock_in)
    begin
        if (miso_oe_in)
            last_reg <= miso_in;
    end
    initial link_out = '{1'b0, 1'b1, 1'b0};
    task automatic xfer(input int nbits, input logic [31:0] tx,
                        output logic [31:0] rx);
        rx = '0;
        @(negedge clock_in) link_out.cs_n <= 1'b0;
        repeat (10) @(negedge clock_in);
        for (int i = nbits - 1; i >= 0; i--)
        begin
            link_out.mosi <= tx[i];
            repeat (5) @(negedge clock_in);
            rx = {rx[30:0], line};
            link_out.sclk <= 1'b1;
            repeat (5) @(negedge clock_in);
            link_out.sclk <= 1'b0;
        end
        repeat (5) @(negedge clock_in);
        link_out.cs_n <= 1'b1;
        repeat (130) @(negedge clock_in);
    endtask : xfer
endmodule : edspi_host_model
`default_nettype wire

// File: verification/edspi_output_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ***********************
// Output control bench
// ***********************
module edspi_output_control_tb
    import edspi_pkg::*;
;
    logic clock_in, rst_in, logic_supply_ok_in, battery_supply_ok_in;
    logic global_output_gate_n_in, coil_above_nominal_in, coil_above_max_in;
    logic ovc_ext, nom_ext, miso_out, miso_oe_out, overcurrent_flag_out;
    logic overcurrent_flag_oe_out, nominal_current_flag_out, awake_out;
    logic nominal_current_flag_oe_out, spark_active_n_out;
    logic spark_active_n_oe_out, ten_cylinder_mode_out;
    logic [3:0] injector_parallel_in, gate_parallel_in, drain_feedback_in;
    logic [3:0] driver_fault_in, injector_drive_out, gate_drive_out;
    logic [3:0] general_gate_mode_out, feedback_diag_enable_out;
    logic [31:0] rx;
    int error_cnt, tests_run;
    edspi_link_type link;
    wire logic sclk_in = link.sclk;
    wire logic cs_n_in = link.cs_n;
    wire logic mosi_in = link.mosi;
    // Flag pins resolve between design and outside driver
    wire logic overcurrent_flag_in =
        overcurrent_flag_oe_out ? overcurrent_flag_out : ovc_ext;
    wire logic nominal_current_flag_in =
        nominal_current_flag_oe_out ? nominal_current_flag_out : nom_ext;
    edspi_output_control #(.POR_FILTER_CYCLES(2)) i_edspi_output_control (.*);
    edspi_host_model i_edspi_host_model (.clock_in(clock_in),
        .link_out(link), .miso_in(miso_out), .miso_oe_in(miso_oe_out));
    initial
    begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    task automatic settle();
        repeat (8) @(negedge clock_in);
    endtask : settle
    task automatic wait_awake(input logic want);
        int n;
        n = 0;
        while (awake_out !== want && n < 400)
        begin
            @(negedge clock_in);
            n++;
        end
        if (n == 400)
        begin
            error_cnt++;
            end_sim();
        end
    endtask : wait_awake
    initial
    begin
        {rst_in, logic_supply_ok_in, battery_supply_ok_in} = 3'h7;
        {global_output_gate_n_in, coil_above_nominal_in} = 2'h0;
        {coil_above_max_in, ovc_ext, nom_ext} = 3'h0;
        {injector_parallel_in, gate_parallel_in} = 8'h00;
        {drain_feedback_in, driver_fault_in} = 8'h03;
        repeat (8) @(negedge clock_in);
        rst_in <= 1'b0;
        wait_awake(1'b1);
        check({injector_drive_out, gate_drive_out}, 32'h0000_0000);
        check(general_gate_mode_out, 32'h0000_0000);
        $display("test reset done");
        i_edspi_host_model.xfer(16, 32'h0000_005A, rx);
        check(rx, 32'h0000_0303);
        check(injector_drive_out, 32'h0000_000A);
        check(gate_drive_out, 32'h0000_0000);
        {injector_parallel_in, gate_parallel_in} <= 8'h52;
        settle();
        check({injector_drive_out, gate_drive_out}, 32'h0000_00F2);
        coil_above_max_in <= 1'b1;
        settle();
        check({overcurrent_flag_out, gate_drive_out}, 32'h0000_0010);
        coil_above_max_in <= 1'b0;
        settle();
        check(gate_drive_out, 32'h0000_0000);
        gate_parallel_in <= 4'h0;
        settle();
        gate_parallel_in <= 4'h2;
        coil_above_nominal_in <= 1'b1;
        drain_feedback_in <= 4'h8;
        settle();
        check(gate_drive_out, 32'h0000_0002);
        check(nominal_current_flag_out, 32'h0000_0001);
        check({spark_active_n_oe_out, spark_active_n_out}, 32'h0000_0002);
        {coil_above_nominal_in, drain_feedback_in} <= 5'h00;
        global_output_gate_n_in <= 1'b1;
        settle();
        $display("test flags done");
        check({injector_drive_out, gate_drive_out}, 32'h0000_0000);
        i_edspi_host_model.xfer(16, 32'h0000_0F30, rx);
        check(rx, 32'h0000_0303);
        check(general_gate_mode_out, 32'h0000_000F);
        check(feedback_diag_enable_out, 32'h0000_000F);
        check({injector_drive_out, gate_drive_out}, 32'h0000_0000);
        global_output_gate_n_in <= 1'b0;
        settle();
        check({injector_drive_out, gate_drive_out}, 32'h0000_0053);
        i_edspi_host_model.xfer(12, 32'h0000_0FFF, rx);
        check(general_gate_mode_out, 32'h0000_000F);
        i_edspi_host_model.xfer(24, 32'h00AB_1001, rx);
        check(rx, 32'h0003_0300);
        check({ten_cylinder_mode_out, overcurrent_flag_oe_out}, 32'h0000_0002);
        check({injector_drive_out, gate_drive_out}, 32'h0000_0052);
        nom_ext <= 1'b1;
        settle();
        check(gate_drive_out, 32'h0000_0000);
        nom_ext <= 1'b0;
        ovc_ext <= 1'b1;
        gate_parallel_in <= 4'h3;
        settle();
        check(gate_drive_out, 32'h0000_0000);
        ovc_ext <= 1'b0;
        gate_parallel_in <= 4'h2;
        logic_supply_ok_in <= 1'b0;
        $display("test commands done");
        wait_awake(1'b0);
        settle();
        check({injector_drive_out, gate_drive_out}, 32'h0000_0000);
        logic_supply_ok_in <= 1'b1;
        wait_awake(1'b1);
        settle();
        check(ten_cylinder_mode_out, 32'h0000_0000);
        check({injector_drive_out, gate_drive_out}, 32'h0000_0052);
        $display("test supply done");
        end_sim();
    end
endmodule : edspi_output_control_tb
`default_nettype wire
